/* core/rtcis_consts.svh */
// register offsets, field positions, reset values and bus codes of the rtc i2c slave
`ifndef RTCIS_CONSTS_SVH
`define RTCIS_CONSTS_SVH
`define RTCIS_SLAVE_ADDR 7'h68
`define RTCIS_REG_SECONDS 4'h1
`define RTCIS_REG_MONTH_CENTURY 4'h6
`define RTCIS_REG_YEAR_COUNT 4'h7
`define RTCIS_REG_FREQ_COMP 4'h8
`define RTCIS_REG_WATCHDOG 4'h9
`define RTCIS_REG_IRQ_CTRL 4'hA
`define RTCIS_REG_FLAGS 4'hF
`define RTCIS_OSC_STOP_BIT 7
`define RTCIS_OUT_LEVEL_BIT 7
`define RTCIS_AFE_BIT 7
`define RTCIS_OSC_FAIL_IRQ_ENABLE_BIT 5
`define RTCIS_OF_BIT 2
`define RTCIS_CENT_MSB 7
`define RTCIS_CENT_LSB 6
`define RTCIS_FREQ_COMP_RST 8'h80
`define RTCIS_REG_RST 8'h00
`define RTCIS_NUM_REGS 16
`define RTCIS_BITS_PER_BYTE 4'h8
`endif

/* core/rtcis_pkg.sv */
// types of the rtc i2c slave
package rtcis_pkg;
    typedef enum logic [2:0] {
        RTCIS_IDLE = 3'b000,
        RTCIS_RX = 3'b001,
        RTCIS_RX_ACK = 3'b010,
        RTCIS_TX = 3'b011,
        RTCIS_TX_ACK = 3'b100,
        RTCIS_IGNORE = 3'b101
    } rtcis_state_t;
    typedef enum logic [1:0] {
        RTCIS_BYTE_ADDR = 2'b00,
        RTCIS_BYTE_PTR = 2'b01,
        RTCIS_BYTE_DATA = 2'b10
    } rtcis_byte_t;
endpackage

/* core/rtcis_sync.sv */
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
module rtcis_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic d,
    output logic q
);
    logic meta_q;
    logic meta_d;
    logic q_d;

    always_comb begin
        meta_d = d;
        q_d = meta_q;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            q <= q_d;
        end
    end
endmodule

/* core/rtcis_top.sv */
// rtc i2c slave: register pointer, century and leap logic, oscillator-fail flag, int pin
`timescale 1ns/1ns
`include "rtcis_consts.svh"
// Function
// RULE1: two-bit century counter increments on century rollover
// RULE2: february 29 in every multiple-of-four year
// RULE3: oscillator stop sets oscillator-fail flag
// RULE4: oscillator-fail flag is set at power-up
// RULE5: low supply or stop bit sets flag
// RULE6: only software writing zero clears flag
// RULE7: host waits four seconds before clearing flag
// RULE8: host restarts oscillator by toggling stop bit
// RULE9: int low while flag and enable set
// RULE10: int follows output level when no interrupt
// RULE11: int pin is open drain, low only
// RULE12: sda edges with scl high are start/stop
// RULE13: data bit taken on each scl pulse
// RULE14: master sends stop before every start
// RULE15: respond only to address 1101000
// RULE16: acknowledge every received byte as receiver
// RULE17: release sda on master non-acknowledge
// RULE18: pointer byte follows write address, low nibble
// RULE19: pointer advances after each byte
// RULE20: write is address, pointer, data, stop
// RULE21: pointed read uses stop and new start
// RULE22: plain read starts one past last access
// RULE23: oscillator stop is seconds register bit 7
// RULE24: output level is bit 7 of register 08h
// RULE25: unmatched address ignored until next start
// RULE26: scl and sda synchronised before decoding
module rtcis_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic int_n_o,
    output logic int_n_oe,
    input wire logic osc_stopped_i,
    input wire logic supply_low_i,
    input wire logic year_tick,
    input wire logic alarm_wd_irq_req,
    output logic osc_run,
    output logic leap_year
);
    logic scl_s;
    logic sda_s;
    logic osc_stop_s;
    logic low_s;
    logic scl_p_q;
    logic sda_p_q;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;

    rtcis_sync #(.RST_VAL(1'b1)) u_sync_scl (
        .clk(clk),
        .nrst(nrst),
        .d(scl_i),
        .q(scl_s)
    );
    rtcis_sync #(.RST_VAL(1'b1)) u_sync_sda (
        .clk(clk),
        .nrst(nrst),
        .d(sda_i),
        .q(sda_s)
    );
    rtcis_sync #(.RST_VAL(1'b0)) u_sync_osc (
        .clk(clk),
        .nrst(nrst),
        .d(osc_stopped_i),
        .q(osc_stop_s)
    );
    rtcis_sync #(.RST_VAL(1'b0)) u_sync_low (
        .clk(clk),
        .nrst(nrst),
        .d(supply_low_i),
        .q(low_s)
    );

    // edges seen only on the synchronised copies
    always_comb begin
        start_det = scl_s && scl_p_q && sda_p_q && !sda_s; // RULE12 RULE26
        stop_det = scl_s && scl_p_q && !sda_p_q && sda_s; // RULE12 RULE26
        scl_rise = scl_s && !scl_p_q;
        scl_fall = !scl_s && scl_p_q;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // bus state machine
    rtcis_pkg::rtcis_state_t state_q;
    rtcis_pkg::rtcis_state_t state_d;
    rtcis_pkg::rtcis_byte_t kind_q;
    rtcis_pkg::rtcis_byte_t kind_d;
    logic [7:0] shreg_q;
    logic [7:0] shreg_d;
    logic [3:0] bitcnt_q;
    logic [3:0] bitcnt_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic read_q;
    logic read_d;
    logic sda_oe_d;
    logic wr_en;
    logic [3:0] wr_idx;
    logic [7:0] wr_data;
    logic [7:0] mem_q [`RTCIS_NUM_REGS];
    logic [7:0] mem_d [`RTCIS_NUM_REGS];
    logic osc_fail_q;
    logic osc_fail_d;
    logic [7:0] rd_data;

    // the flag lives outside the array so a write cannot mask a set event
    always_comb begin
        rd_data = mem_q[ptr_q[3:0]]; // RULE18
        if (ptr_q[3:0] == `RTCIS_REG_FLAGS) begin
            rd_data[`RTCIS_OF_BIT] = osc_fail_q;
        end
    end

    always_comb begin
        state_d = state_q;
        kind_d = kind_q;
        shreg_d = shreg_q;
        bitcnt_d = bitcnt_q;
        ptr_d = ptr_q;
        read_d = read_q;
        sda_oe_d = sda_oe;
        wr_en = 1'b0;
        wr_idx = ptr_q[3:0];
        wr_data = shreg_q;
        if (stop_det) begin
            state_d = rtcis_pkg::RTCIS_IDLE;
            sda_oe_d = 1'b0;
        end else if (start_det) begin
            // a repeated start is not legal here but is decoded as a start anyway
            state_d = rtcis_pkg::RTCIS_RX; // RULE14
            kind_d = rtcis_pkg::RTCIS_BYTE_ADDR;
            bitcnt_d = 4'h0;
            sda_oe_d = 1'b0;
        end else begin
            unique case (state_q)
                rtcis_pkg::RTCIS_IDLE, rtcis_pkg::RTCIS_IGNORE: begin
                    sda_oe_d = 1'b0; // RULE25
                end
                rtcis_pkg::RTCIS_RX: begin
                    if (scl_rise && bitcnt_q != `RTCIS_BITS_PER_BYTE) begin
                        shreg_d = {shreg_q[6:0], sda_s}; // RULE13
                        bitcnt_d = bitcnt_q + 4'h1;
                    end else if (scl_fall && bitcnt_q == `RTCIS_BITS_PER_BYTE) begin
                        bitcnt_d = 4'h0;
                        state_d = rtcis_pkg::RTCIS_RX_ACK;
                        sda_oe_d = 1'b1; // RULE16
                        unique case (kind_q)
                            rtcis_pkg::RTCIS_BYTE_ADDR: begin
                                if (shreg_q[7:1] == `RTCIS_SLAVE_ADDR) begin // RULE15
                                    read_d = shreg_q[0];
                                    kind_d = rtcis_pkg::RTCIS_BYTE_PTR;
                                end else begin
                                    state_d = rtcis_pkg::RTCIS_IGNORE; // RULE25
                                    sda_oe_d = 1'b0;
                                end
                            end
                            rtcis_pkg::RTCIS_BYTE_PTR: begin
                                ptr_d = shreg_q; // RULE18 RULE20
                                kind_d = rtcis_pkg::RTCIS_BYTE_DATA;
                            end
                            default: begin
                                wr_en = 1'b1; // RULE20
                                ptr_d = ptr_q + 8'h01; // RULE19
                            end
                        endcase
                    end
                end
                rtcis_pkg::RTCIS_RX_ACK: begin
                    if (scl_fall) begin
                        if (read_q) begin
                            // pointer already sits one past the last access
                            shreg_d = rd_data; // RULE21 RULE22
                            ptr_d = ptr_q + 8'h01; // RULE19
                            sda_oe_d = !rd_data[7];
                            bitcnt_d = 4'h1;
                            state_d = rtcis_pkg::RTCIS_TX;
                        end else begin
                            sda_oe_d = 1'b0;
                            state_d = rtcis_pkg::RTCIS_RX;
                        end
                    end
                end
                rtcis_pkg::RTCIS_TX: begin
                    if (scl_fall) begin
                        if (bitcnt_q == `RTCIS_BITS_PER_BYTE) begin
                            sda_oe_d = 1'b0;
                            state_d = rtcis_pkg::RTCIS_TX_ACK;
                        end else begin
                            shreg_d = {shreg_q[6:0], 1'b0};
                            sda_oe_d = !shreg_q[6];
                            bitcnt_d = bitcnt_q + 4'h1;
                        end
                    end
                end
                rtcis_pkg::RTCIS_TX_ACK: begin
                    if (scl_rise && sda_s) begin
                        state_d = rtcis_pkg::RTCIS_IGNORE; // RULE17
                    end else if (scl_fall) begin
                        shreg_d = rd_data;
                        ptr_d = ptr_q + 8'h01; // RULE19
                        sda_oe_d = !rd_data[7];
                        bitcnt_d = 4'h1;
                        state_d = rtcis_pkg::RTCIS_TX;
                    end
                end
                default: begin
                    state_d = rtcis_pkg::RTCIS_IDLE;
                    sda_oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= rtcis_pkg::RTCIS_IDLE;
            kind_q <= rtcis_pkg::RTCIS_BYTE_ADDR;
            shreg_q <= 8'h00;
            bitcnt_q <= 4'h0;
            ptr_q <= 8'h00;
            read_q <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            shreg_q <= shreg_d;
            bitcnt_q <= bitcnt_d;
            ptr_q <= ptr_d;
            read_q <= read_d;
            sda_oe <= sda_oe_d;
        end
    end

    // register file, year and century roll
    logic [7:0] year_v;
    logic [1:0] cent_v;
    logic leap_d;

    always_comb begin
        for (int i = 0; i < `RTCIS_NUM_REGS; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (wr_en) begin
            mem_d[wr_idx] = wr_data;
        end
        year_v = mem_d[`RTCIS_REG_YEAR_COUNT];
        cent_v = mem_d[`RTCIS_REG_MONTH_CENTURY][`RTCIS_CENT_MSB:`RTCIS_CENT_LSB];
        if (year_tick) begin
            if (year_v[3:0] != 4'h9) begin
                year_v[3:0] = year_v[3:0] + 4'h1;
            end else if (year_v[7:4] != 4'h9) begin
                year_v = {year_v[7:4] + 4'h1, 4'h0};
            end else begin
                year_v = 8'h00;
                cent_v = cent_v + 2'h1; // RULE1
            end
        end
        mem_d[`RTCIS_REG_YEAR_COUNT] = year_v;
        mem_d[`RTCIS_REG_MONTH_CENTURY][`RTCIS_CENT_MSB:`RTCIS_CENT_LSB] = cent_v; // RULE1
        // bcd multiple of four; the 100 and 400 exceptions are left to software
        if (!year_v[4]) begin
            leap_d = year_v[3:0] == 4'h0 || year_v[3:0] == 4'h4 || year_v[3:0] == 4'h8; // RULE2
        end else begin
            leap_d = year_v[3:0] == 4'h2 || year_v[3:0] == 4'h6; // RULE2
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < `RTCIS_NUM_REGS; i++) begin
                mem_q[i] <= `RTCIS_REG_RST;
            end
            mem_q[`RTCIS_REG_FREQ_COMP] <= `RTCIS_FREQ_COMP_RST;
            leap_year <= 1'b1;
        end else begin
            for (int i = 0; i < `RTCIS_NUM_REGS; i++) begin
                mem_q[i] <= mem_d[i];
            end
            leap_year <= leap_d;
        end
    end

    // oscillator-fail flag and int pin
    logic stop_bit;
    logic osc_fail_irq_enable;
    logic fallback;
    logic int_low_d;

    always_comb begin
        stop_bit = mem_q[`RTCIS_REG_SECONDS][`RTCIS_OSC_STOP_BIT]; // RULE23
        osc_fail_irq_enable = mem_q[`RTCIS_REG_IRQ_CTRL][`RTCIS_OSC_FAIL_IRQ_ENABLE_BIT];
        osc_fail_d = osc_fail_q;
        if (wr_en && wr_idx == `RTCIS_REG_FLAGS && !wr_data[`RTCIS_OF_BIT]) begin
            osc_fail_d = 1'b0; // RULE6
        end
        // set wins over a clear in the same cycle
        if (osc_stop_s || low_s || stop_bit) begin
            osc_fail_d = 1'b1; // RULE3 RULE5
        end
        fallback = !osc_fail_irq_enable && !mem_q[`RTCIS_REG_IRQ_CTRL][`RTCIS_AFE_BIT]
            && mem_q[`RTCIS_REG_WATCHDOG] == 8'h00;
        if (osc_fail_q && osc_fail_irq_enable) begin
            int_low_d = 1'b1; // RULE9
        end else if (fallback) begin
            int_low_d = !mem_q[`RTCIS_REG_FREQ_COMP][`RTCIS_OUT_LEVEL_BIT]; // RULE10 RULE24
        end else begin
            int_low_d = alarm_wd_irq_req;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            osc_fail_q <= 1'b1; // RULE4
            int_n_oe <= 1'b0;
            int_n_o <= 1'b0;
            sda_o <= 1'b0;
            osc_run <= 1'b1;
        end else begin
            osc_fail_q <= osc_fail_d;
            int_n_oe <= int_low_d; // RULE11
            int_n_o <= 1'b0; // RULE11
            sda_o <= 1'b0;
            osc_run <= !stop_bit; // RULE23
        end
    end
endmodule

/* tb/rtcis_i2c_master.sv */
// behavioural i2c bus master for the rtc slave
`timescale 1ns/1ns
module rtcis_i2c_master (
    input wire logic clk,
    output logic scl,
    output logic sda_m,
    input wire logic sda_bus,
    output logic [8:0] rx_data,
    output logic rx_stb
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
        rx_data = '0;
        rx_stb = 1'b0;
    end
    // one 125 ns scl pulse; sda moves only while scl is low
    task automatic bit_io(input logic b, output logic s);
        #30 sda_m = b;
        #35 scl = 1'b1;
        #55 s = sda_bus;
        #5 scl = 1'b0;
    endtask
    // only called on an idle bus: every frame is closed by stop first
    // frames begin just off a clock edge so no pin ever moves on a sampling edge
    task automatic start();
        @(negedge clk);
        #2 sda_m = 1'b0;
        #60 scl = 1'b0;
    endtask
    task automatic stop();
        #30 sda_m = 1'b0;
        #35 scl = 1'b1;
        #60 sda_m = 1'b1;
        #130;
    endtask
    // ackbit high leaves the ninth slot released; a read ends that way
    task automatic xfer(input logic [7:0] tx, input logic ackbit);
        logic [8:0] v;
        logic [8:0] r;
        v = {tx, ackbit};
        for (int i = 8; i >= 0; i--) begin
            bit_io(v[i], r[i]);
        end
        rx_data = r;
        rx_stb = ~rx_stb;
    endtask
endmodule

/* tb/rtcis_top_properties.sv */
// concurrent checks on the pins of the rtc i2c slave
`timescale 1ns/1ns
module rtcis_top_properties (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic int_n_o,
    input wire logic int_n_oe,
    input wire logic year_tick,
    input wire logic osc_run,
    input wire logic leap_year
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // the answer lags the pin by the synchroniser, so look some samples back
    sequence scl_fell_before;
        !scl_i && !$past(scl_i, 2) && $past(scl_i, 6);
    endsequence
    sequence stop_seen;
        scl_i && $past(scl_i) && $rose(sda_i);
    endsequence
    a_sda_low_only: assert property (sda_oe |-> !sda_o)
        else $error("sda driven high");
    a_int_low_only: assert property (int_n_oe |-> !int_n_o)
        else $error("int driven high");
    a_oe_after_fall: assert property ($changed(sda_oe) |-> scl_fell_before)
        else $error("sda drive moved outside scl low");
    a_oe_steady_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
        else $error("sda drive moved in scl high");
    a_ack_holds: assert property (sda_oe && $rose(scl_i) |-> sda_oe [*4])
        else $error("sda low not held in scl high");
    a_stop_released: assert property (stop_seen |-> !sda_oe [*8])
        else $error("sda held after stop");
    a_reset_values: assert property ($rose(nrst) |-> leap_year && osc_run)
        else $error("bad levels after reset");
    a_int_reset_off: assert property ($rose(nrst) |-> !int_n_oe ##1 !int_n_oe)
        else $error("int pulled after reset");
    a_leap_after_tick: assert property (year_tick && leap_year |-> ##[1:3] !leap_year)
        else $error("leap flag kept after tick");
    cover property (stop_seen);
endmodule

/* tb/rtcis_top_tb.sv */
// self-checking testbench of the rtc i2c slave
`timescale 1ns/1ns
`define MST rtcis_i2c_master_inst
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module rtcis_top_tb;
    logic clk;
    logic nrst;
    logic scl;
    logic sda_m;
    logic sda_bus;
    logic int_pin;
    logic osc_stopped;
    logic supply_low;
    logic year_tick;
    logic alarm_req;
    logic sda_o;
    logic sda_oe;
    logic int_n_o;
    logic int_n_oe;
    logic osc_run;
    logic leap_year;
    logic rx_stb;
    logic pin_stb;
    logic pin_val;
    logic ep;
    logic [8:0] eb;
    logic [8:0] rx_data;
    logic [8:0] exp_q[$];
    logic pin_q[$];
    logic [7:0] a;
    int err_total;
    int n_tests;
    int cyc;
    int d;
    integer seed;
    // open-drain lines with pull-ups: any low driver wins
    assign sda_bus = sda_m & ~(sda_oe & ~sda_o);
    assign int_pin = ~(int_n_oe & ~int_n_o);
    rtcis_top rtcis_top_inst (.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda_bus),
        .sda_o(sda_o), .sda_oe(sda_oe), .int_n_o(int_n_o), .int_n_oe(int_n_oe),
        .osc_stopped_i(osc_stopped), .supply_low_i(supply_low), .year_tick(year_tick),
        .alarm_wd_irq_req(alarm_req), .osc_run(osc_run), .leap_year(leap_year));
    rtcis_i2c_master rtcis_i2c_master_inst (.clk(clk), .scl(scl), .sda_m(sda_m),
        .sda_bus(sda_bus), .rx_data(rx_data), .rx_stb(rx_stb));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // guards skip the x-to-0 step of the strobes at time zero
    always @(rx_stb) if (exp_q.size() != 0) begin
        eb = exp_q.pop_front();
        `CHK("byte", eb, rx_data)
    end
    always @(pin_stb) if (pin_q.size() != 0) begin
        ep = pin_q.pop_front();
        `CHK("pin", ep, pin_val)
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            results();
        end
    end
    task automatic results();
        if (exp_q.size() != 0 || pin_q.size() != 0) err_total++;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (8) @(negedge clk);
    endtask
    task automatic look(input logic e, input logic g);
        pin_q.push_back(e);
        pin_val = g;
        pin_stb = ~pin_stb;
        // let the watcher take this note before the next one is queued
        @(negedge clk);
    endtask
    task automatic tx(input logic [7:0] b, input logic ack);
        exp_q.push_back({b, ack});
        `MST.xfer(b, 1'b1);
    endtask
    task automatic rx(input logic [7:0] e, input logic last);
        exp_q.push_back({e, last});
        `MST.xfer(8'hFF, last);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] v);
        `MST.start();
        tx(8'hD0, 1'b0);
        tx(p, 1'b0);
        tx(v, 1'b0);
        `MST.stop();
        settle();
    endtask
    task automatic rd_at(input logic [7:0] p, input logic [7:0] e);
        `MST.start();
        tx(8'hD0, 1'b0);
        tx(p, 1'b0);
        `MST.stop();
        `MST.start();
        tx(8'hD1, 1'b0);
        rx(e, 1'b1);
        `MST.stop();
    endtask
    task automatic pulse();
        year_tick = 1'b1;
        @(negedge clk);
        year_tick = 1'b0;
        settle();
    endtask
    initial begin
        nrst = 1'b0;
        osc_stopped = 1'b0;
        supply_low = 1'b0;
        year_tick = 1'b0;
        alarm_req = 1'b0;
        pin_stb = 1'b0;
        pin_val = 1'b0;
        err_total = 0;
        n_tests = 0;
        cyc = 0;
        seed = 32'hf52b7f56;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        settle();
        look(1'b1, osc_run);
        look(1'b1, leap_year);
        look(1'b1, int_pin);
        `MST.start();
        tx(8'hD0, 1'b0);
        tx(8'h0F, 1'b0);
        `MST.stop();
        for (int k = 0; k < 2; k++) begin
            `MST.start();
            tx(8'hD1, 1'b0);
            rx(8'h04, 1'b1);
            `MST.stop();
            wr(8'h0F, 8'h04);
            `MST.start();
            tx(8'hD0, 1'b0);
            tx(8'h0F, 1'b0);
            `MST.stop();
        end
        `MST.start();
        tx(8'hD0, 1'b0);
        tx(8'hFA, 1'b0);
        tx(8'h20, 1'b0);
        tx(8'h3C, 1'b0);
        tx(8'hC3, 1'b0);
        `MST.stop();
        settle();
        look(1'b0, int_pin);
        rd_at(8'h0B, 8'h3C);
        `MST.start();
        tx(8'hD1, 1'b0);
        rx(8'hC3, 1'b0);
        rx(8'h00, 1'b1);
        `MST.stop();
        for (int k = 0; k < 4; k++) begin
            a = 8'($random(seed));
            if (a[7:1] == 7'h68) a[1] = ~a[1];
            `MST.start();
            tx(a, 1'b1);
            tx(8'hD0, 1'b1);
            `MST.stop();
        end
        for (int k = 0; k < 3; k++) begin
            wr(8'h0F, 8'h00);
            look(1'b1, int_pin);
            if (k == 2) wr(8'h01, 8'h80);
            else begin
                {osc_stopped, supply_low} = 2'b01 << k;
                settle();
                {osc_stopped, supply_low} = 2'b00;
            end
            settle();
            look(1'b0, int_pin);
        end
        look(1'b0, osc_run);
        wr(8'h01, 8'h00);
        look(1'b1, osc_run);
        wr(8'h0A, 8'h00);
        for (int k = 0; k < 2; k++) begin
            wr(8'h08, 8'(k << 7));
            look(k[0], int_pin);
        end
        wr(8'h09, 8'h0E);
        for (int k = 0; k < 3; k++) begin
            alarm_req = 1'($random(seed));
            settle();
            look(~alarm_req, int_pin);
        end
        wr(8'h09, 8'h00);
        alarm_req = 1'b1;
        wr(8'h0A, 8'h80);
        look(1'b0, int_pin);
        wr(8'h07, 8'h99);
        wr(8'h06, 8'hC3);
        pulse();
        rd_at(8'h06, 8'h03);
        for (int k = 0; k < 6; k++) begin
            d = (k == 0) ? 96 : {$random(seed)} % 99;
            wr(8'h07, 8'((d / 10) * 16 + d % 10));
            look(d % 4 == 0, leap_year);
            pulse();
            look((d + 1) % 4 == 0, leap_year);
        end
        settle();
        results();
    end
endmodule
bind rtcis_top rtcis_top_properties rtcis_top_properties_inst (.clk(clk), .nrst(nrst),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .int_n_o(int_n_o),
    .int_n_oe(int_n_oe), .year_tick(year_tick), .osc_run(osc_run), .leap_year(leap_year));
